// >>> include/rlnc_defs.svh
// constants for the rotate-left-without-carry execution block
// assumes inclusion by bare name from the package and the exec rtl file
`ifndef RLNC_DEFS_SVH
`define RLNC_DEFS_SVH
`define RLNC_OPCODE_HI      6'h11      // top six bits 010001 of the word
`define RLNC_OPCODE_VAL     6'h11      // value compared against bits 15..10
`define RLNC_DEST_BIT       9
`define RLNC_BANK_BIT       8
`define RLNC_IDX_LIMIT      8'h5F      // indexed offset applies at or below this
`define RLNC_ACCESS_SPLIT   8'h60      // access bank low half ends below this
`define RLNC_SFR_BANK       4'hF       // upper access half maps to this bank
`define RLNC_BANK_RST       4'h0
`define RLNC_WREG_RST       8'h00
`endif

// >>> include/rlnc_pkg.sv
// types for the rotate-left-without-carry execution block
// assumes rlnc_defs.svh is on the include path
`default_nettype none
`include "rlnc_defs.svh"
package rlnc_pkg;
  // four quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    RLNC_Q1,
    RLNC_Q2,
    RLNC_Q3,
    RLNC_Q4
  } rlnc_phase_type;
endpackage : rlnc_pkg
`default_nettype wire

// >>> rtl/rlnc_rotator.sv
// combinational rotate and flag computation
// assumes a plain 8-bit operand from the caller
`default_nettype none
module rlnc_rotator #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] operand_in,
  output logic      [WIDTH-1:0] result_out,
  output logic                  msb_flag_out,
  output logic                  zero_flag_out
);
  // ****************************************
  // rotate one place left, msb wraps to bit 0
  // ****************************************
  always_comb begin
    result_out    = {operand_in[WIDTH-2:0], operand_in[WIDTH-1]};
    msb_flag_out  = result_out[WIDTH-1];
    zero_flag_out = (result_out == '0);
  end
endmodule : rlnc_rotator
`default_nettype wire

// >>> rtl/rlnc_exec.sv
// execution unit for the rotate_left_nocarry_op instruction
// assumes a file-register memory outside, read combinationally by address,
// and a fetch stage presenting one instruction word per instruction cycle
//
// How it works
// - rotate the file register left by one
// - destination bit 0 writes accumulator only
// - destination bit 1 writes back to file
// - bank bit 0 uses access bank
// - bank bit 1 uses bank_pointer
// - extended set, access, low offset: indexed
// - one word, one instruction cycle
// - decode, read, process, write per quarter
// - old bit 7 lands in bit 0
// - only msb and zero flags change
// - opcode 010001 then d, a, address
`default_nettype none
`include "rlnc_defs.svh"
module rlnc_exec #(
  parameter int WIDTH = 8
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [15:0]             instr_word,
  input  wire logic                    instr_valid,
  input  wire logic                    ext_set_en,
  input  wire logic [3:0]              bank_pointer,
  input  wire logic [11:0]             index_base,
  input  wire logic [WIDTH-1:0]        file_rd_data,
  output logic      [11:0]             file_addr,
  output logic                         file_wr_en,
  output logic      [WIDTH-1:0]        file_wr_data,
  output logic      [WIDTH-1:0]        wreg,
  output logic                         msb_result_flg,
  output logic                         null_result_flg,
  output logic                         flags_wr_en,
  output logic                         op_hit,
  output rlnc_pkg::rlnc_phase_type     phase,
  output logic                         done
);
  import rlnc_pkg::*;

  // ****************************************
  // state declarations
  // ****************************************
  rlnc_phase_type   phase_q, phase_d;     // current quarter
  logic             active_q, active_d;   // instruction in flight
  logic             dest_q, dest_d;       // latched destination bit
  logic [11:0]      addr_q, addr_d;       // resolved operand address
  logic [WIDTH-1:0] opnd_q, opnd_d;       // operand read in Q2
  logic [WIDTH-1:0] res_q, res_d;         // result formed in Q3
  logic             nflg_q, nflg_d;       // msb flag holding
  logic             zflg_q, zflg_d;       // zero flag holding
  logic [WIDTH-1:0] wreg_q, wreg_d;       // accumulator
  logic             fwr_q, fwr_d;         // file write strobe
  logic             flwr_q, flwr_d;       // flag write strobe
  logic             done_q, done_d;       // end-of-instruction pulse
  logic [WIDTH-1:0] rot_res;              // rotator output
  logic             rot_n;                // rotator msb flag
  logic             rot_z;                // rotator zero flag
  logic             match;                // opcode recognised
  logic [11:0]      eff_addr;             // address from the word

  // ****************************************
  // data path
  // ****************************************
  rlnc_rotator #(
    .WIDTH (WIDTH)
  ) u_rot (
    .operand_in    (opnd_q),
    .result_out    (rot_res),
    .msb_flag_out  (rot_n),
    .zero_flag_out (rot_z)
  );

  // ****************************************
  // decode and address resolution
  // ****************************************
  always_comb begin
    match = (instr_word[15:10] == `RLNC_OPCODE_VAL);
    if (instr_word[`RLNC_BANK_BIT]) begin
      eff_addr = {bank_pointer, instr_word[7:0]};
    end else if (ext_set_en && (instr_word[7:0] <= `RLNC_IDX_LIMIT)) begin
      eff_addr = index_base + {4'h0, instr_word[7:0]};
    end else if (instr_word[7:0] < `RLNC_ACCESS_SPLIT) begin
      eff_addr = {4'h0, instr_word[7:0]}; // access bank low half
    end else begin
      eff_addr = {`RLNC_SFR_BANK, instr_word[7:0]}; // access bank high half
    end
  end

  // ****************************************
  // quarter sequencer and pipeline next state
  // ****************************************
  always_comb begin
    phase_d  = phase_q;
    active_d = active_q;
    dest_d   = dest_q;
    addr_d   = addr_q;
    opnd_d   = opnd_q;
    res_d    = res_q;
    nflg_d   = nflg_q;
    zflg_d   = zflg_q;
    wreg_d   = wreg_q;
    fwr_d    = 1'b0;
    flwr_d   = 1'b0;
    done_d   = 1'b0;
    unique case (phase_q)
      RLNC_Q1: begin
        // decode: take the word only at a cycle boundary
        active_d = instr_valid && match;
        if (instr_valid && match) begin
          dest_d = instr_word[`RLNC_DEST_BIT];
          addr_d = eff_addr;
        end
        phase_d = RLNC_Q2;
      end
      RLNC_Q2: begin
        // read the operand
        if (active_q) begin
          opnd_d = file_rd_data;
        end
        phase_d = RLNC_Q3;
      end
      RLNC_Q3: begin
        // process: rotate and form flags
        if (active_q) begin
          res_d  = rot_res;
          nflg_d = rot_n;
          zflg_d = rot_z;
        end
        phase_d = RLNC_Q4;
      end
      RLNC_Q4: begin
        // write destination and flags, instruction finishes
        if (active_q) begin
          if (dest_q) begin
            fwr_d = 1'b1;
          end else begin
            wreg_d = res_q;
          end
          flwr_d = 1'b1;
          done_d = 1'b1;
        end
        active_d = 1'b0;
        phase_d  = RLNC_Q1;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_q  <= RLNC_Q1;
      active_q <= 1'b0;
      dest_q   <= 1'b1;
      addr_q   <= 12'h000;
      opnd_q   <= '0;
      res_q    <= '0;
      nflg_q   <= 1'b0;
      zflg_q   <= 1'b0;
      wreg_q   <= '0;
      fwr_q    <= 1'b0;
      flwr_q   <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      phase_q  <= phase_d;
      active_q <= active_d;
      dest_q   <= dest_d;
      addr_q   <= addr_d;
      opnd_q   <= opnd_d;
      res_q    <= res_d;
      nflg_q   <= nflg_d;
      zflg_q   <= zflg_d;
      wreg_q   <= wreg_d;
      fwr_q    <= fwr_d;
      flwr_q   <= flwr_d;
      done_q   <= done_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    file_addr       = addr_q;
    file_wr_en      = fwr_q;   // never set when dest bit is 0
    file_wr_data    = res_q;
    wreg            = wreg_q;
    msb_result_flg  = nflg_q;
    null_result_flg = zflg_q;
    flags_wr_en     = flwr_q;
    op_hit          = instr_valid && match && (phase_q == RLNC_Q1);
    phase           = phase_q;
    done            = done_q;
  end
endmodule : rlnc_exec
`default_nettype wire

// >>> verif/rlnc_exec_monitor.sv
// port assertions for the rotate execution unit
// assumes binding onto rlnc_exec, one clock
`default_nettype none
module rlnc_exec_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] instr_word,
  input wire logic [3:0]  bank_pointer,
  input wire logic [11:0] index_base,
  input wire logic        ext_set_en,
  input wire logic [7:0]  file_rd_data,
  input wire logic [11:0] file_addr,
  input wire logic        file_wr_en,
  input wire logic [7:0]  file_wr_data,
  input wire logic        msb_result_flg,
  input wire logic        null_result_flg,
  input wire logic        flags_wr_en,
  input wire logic        op_hit,
  input wire logic        done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_done_four_on: assert property (op_hit |-> ##4 done)
    else $error("done late");
  a_strobe_pair: assert property (done |-> flags_wr_en && $past(op_hit, 4))
    else $error("stray strobe");
  a_dest_select: assert property (done |-> file_wr_en == $past(instr_word[9], 4))
    else $error("wrong target");
  // operand is taken at the q2 edge, three edges before the write strobe is seen
  a_rotate_data: assert property (file_wr_en |-> file_wr_data == {$past(file_rd_data[6:0], 3),
    $past(file_rd_data[7], 3)}) else $error("bad rotate");
  a_msb_flag: assert property (flags_wr_en |-> msb_result_flg == $past(file_rd_data[6], 3))
    else $error("bad n flag");
  a_zero_flag: assert property (flags_wr_en |-> null_result_flg == ($past(file_rd_data, 3) == 8'h00))
    else $error("bad z flag");
  a_bank_addr: assert property (op_hit && instr_word[8] |=>
    file_addr == {$past(bank_pointer), $past(instr_word[7:0])}) else $error("bad bank address");
  a_index_addr: assert property (op_hit && !instr_word[8] && ext_set_en && instr_word[7:0] <= 8'h5F |=>
    file_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])}) else $error("bad indexed address");
  a_access_addr: assert property (op_hit && !instr_word[8] && !ext_set_en && instr_word[7:0] < 8'h60 |=>
    file_addr == {4'h0, $past(instr_word[7:0])}) else $error("bad access address");
endmodule : rlnc_exec_monitor
bind rlnc_exec rlnc_exec_monitor u_mon (.clk_sys, .rst, .instr_word, .bank_pointer, .index_base, .ext_set_en,
  .file_rd_data, .file_addr, .file_wr_en, .file_wr_data, .msb_result_flg, .null_result_flg, .flags_wr_en,
  .op_hit, .done);
`default_nettype wire

// >>> verif/rlnc_exec_test.sv
// self-checking bench for the rotate execution unit
// assumes rlnc_pkg and the monitor are compiled first
`default_nettype none
module rlnc_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rlnc_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_pointer = 4'h0;
  logic [11:0] index_base = 12'h000, file_addr;
  logic [7:0] file_rd_data = 8'h00, file_wr_data, wreg;
  logic file_wr_en, msb_result_flg, null_result_flg, flags_wr_en, op_hit, done;
  rlnc_phase_type phase;
  int error_cnt = 0, n_compared = 0;
  always #10 clk_sys = ~clk_sys;
  rlnc_exec dut (.clk_sys, .rst, .instr_word, .instr_valid, .ext_set_en, .bank_pointer, .index_base,
    .file_rd_data, .file_addr, .file_wr_en, .file_wr_data, .wreg, .msb_result_flg, .null_result_flg,
    .flags_wr_en, .op_hit, .phase, .done);
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // issue one word in a q1 cycle, judge address and write-back
  task automatic exec(logic [15:0] w, logic [7:0] rd, logic ext, logic [3:0] bp, logic [11:0] ib, logic [11:0] ea);
    logic [7:0] r;
    logic hit;
    r = {rd[6:0], rd[7]};
    hit = (w[15:10] == 6'h11);
    do @(negedge clk_sys); while (phase !== RLNC_Q4);
    @(posedge clk_sys);
    instr_word <= w;
    instr_valid <= 1'b1;
    file_rd_data <= rd;
    ext_set_en <= ext;
    bank_pointer <= bp;
    index_base <= ib;
    @(negedge clk_sys);
    chk("op_hit", op_hit, hit);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    @(negedge clk_sys);
    if (hit) chk("file_addr", file_addr, ea);
    chk("phase", phase, RLNC_Q2);
    repeat (3) @(negedge clk_sys);
    chk("done", done, hit);
    if (hit) begin
      chk("wr_en", file_wr_en, w[9]);
      chk("flags_wr", flags_wr_en, 1'b1);
      chk("n_flag", msb_result_flg, r[7]);
      chk("z_flag", null_result_flg, r == 8'h00);
      chk("result", w[9] ? file_wr_data : wreg, r);
    end
  endtask : exec
  // write back through bank pointer
  task automatic t_file_bank();
    exec(16'h4712, 8'hAB, 1'b0, 4'h3, 12'h000, 12'h312);
  endtask : t_file_bank
  // accumulator target, access bank low half
  task automatic t_wreg_access();
    exec(16'h4420, 8'h80, 1'b0, 4'h3, 12'h000, 12'h020);
  endtask : t_wreg_access
  // mid-run reset returns sequencer, accumulator and address to rest
  task automatic t_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("rst_phase", phase, RLNC_Q1);
    chk("rst_wreg", wreg, 8'h00);
    chk("rst_addr", file_addr, 12'h000);
    chk("rst_done", done, 1'b0);
  endtask : t_reset
  // indexed at the top offset
  task automatic t_indexed();
    exec(16'h465F, 8'h40, 1'b1, 4'h3, 12'h100, 12'h15F);
  endtask : t_indexed
  // just above the indexed limit, zero result
  task automatic t_access_hi();
    exec(16'h4660, 8'h00, 1'b1, 4'h3, 12'h100, 12'hF60);
  endtask : t_access_hi
  // neighbouring opcode must do nothing
  task automatic t_bad_op();
    exec(16'h4312, 8'hAB, 1'b0, 4'h3, 12'h000, 12'h000);
  endtask : t_bad_op
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_file_bank();
    t_wreg_access();
    t_reset();
    t_indexed();
    t_access_hi();
    t_bad_op();
    end_sim();
  end
  // watchdog, far beyond five instructions
  initial begin
    #20_000;
    error_cnt++;
    end_sim();
  end
endmodule : rlnc_exec_test
`default_nettype wire
